// ==== msi_init_regs.sv ====
`include "msi_defs.svh"
// Summary of operation
// RL1 - Host clears transmit and receive enables and polls until both read zero.
// RL2 - Writing the MAC soft-reset bit starts a reset; the bit clears itself afterwards.
// RL3 - Host should soft-reset the MAC after any speed or duplex change.
// RL4 - Host finally sets both enables and polls until they read back set.
// RL5 - Command bits 15:0 hold enables, speed, filtering, duplex, reset and loopback controls.
// RL6 - Command bits 31:16 hold address select, sleep controls, checks; 30:27 reserved.
// RL7 - Host sets section-empty to depth minus 16, almost thresholds to 3 or 8.
// RL8 - Section-full 16 gives cut-through; zero selects store-and-forward per direction.
// RL9 - Station address: four octets low word, first octet lowest; two octets second word.
// RL10 - Host sets frame length 1518, gap 12, pause quanta maximum.
// RL11 - With the sublayer, host clears speed bits 3 and 25, half duplex per status.
// RL12 - SGMII link timer 1.6 ms: 0x0D40 low word, 0x03 high word.
// RL13 - 1000BASE-X link timer 10 ms: 0x12D0 low word, 0x13 high word.
// RL14 - Interface mode 0x0003 selects SGMII with negotiation; 0x0000 is default 1000BASE-X.
// RL15 - Host enables negotiation with 0x1140; bits 6, 8, 13 free in SGMII.
// RL16 - In 1000BASE-X, sublayer control bits 6, 8 and 13 ignore writes.
// RL17 - Writing 0x9140 starts a sublayer reset; the reset bit clears itself.
// RL18 - Host should reset the sublayer after any sublayer configuration change.
// RL19 - Offsets 0x80 to 0x9F become MDIO accesses to PHY registers 0 to 31.
// RL20 - Mode bit 0 selects SGMII; bit 1 uses partner-negotiated abilities.
// RL21 - Registers sit on a 32-bit word port that shows busy during each access.
// RL22 - Host does PHY, then sublayer, then MAC setup, finishing each poll first.
module msi_init_regs #(
  parameter int MDC_DIV = `MSI_MDC_DIV,
  parameter int MAC_RST_CYC = `MSI_MAC_RST_CYC,
  parameter int PCS_RST_CYC = `MSI_PCS_RST_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register port
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [7:0] ADDRESS,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // MDIO to external PHY
  output logic MDC,
  output logic MDIO_OUT,
  output logic MDIO_OE_N,
  input wire logic MDIO_IN,
  // Configuration to datapath
  output msi_pkg::msi_cfg_t CFG,
  output logic MAC_RESET,
  output logic PCS_RESET,
  output logic TX_STORE_FWD,
  output logic RX_STORE_FWD
);
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  msi_pkg::msi_state_t st_q;
  logic req;
  logic is_mdio;
  logic acc_wr;
  logic acc_rd;
  logic mdio_done;
  logic [31:0] rd_mux;
  logic [31:0] cmd_q;
  logic [31:0] mac0_q;
  logic [15:0] mac1_q, frm_len_q, ipg_q, pause_q, pcs_ctrl_q, if_mode_q, tmr_lo_q, tmr_hi_q;
  logic [15:0] tx_se_q, tx_sf_q, rx_se_q, rx_sf_q, tx_ae_q, tx_af_q, rx_ae_q, rx_af_q;
  logic [4:0] phy_addr_q;
  logic [15:0] mdio_cap_q;

  assign req = READ | WRITE;
  assign is_mdio = (ADDRESS >= `MSI_OFS_MDIO_LO) && (ADDRESS <= `MSI_OFS_MDIO_HI);
  assign acc_wr = (st_q == msi_pkg::MSI_IDLE) && WRITE && !is_mdio;
  assign acc_rd = (st_q == msi_pkg::MSI_IDLE) && READ && !WRITE && !is_mdio;

  // ----------------------------------------
  // Port handshake
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_q <= msi_pkg::MSI_IDLE;
      WAITREQUEST <= 1'b1;
      READDATA <= 32'h00000000;
    end
    else
    begin
      case (st_q)
        msi_pkg::MSI_IDLE:
        begin
          if (req && is_mdio)
          begin
            st_q <= msi_pkg::MSI_MDIO; // RL19
          end
          else if (req)
          begin
            READDATA <= rd_mux;
            WAITREQUEST <= 1'b0; // RL21
            st_q <= msi_pkg::MSI_DONE;
          end
        end
        msi_pkg::MSI_MDIO:
        begin
          if (mdio_done)
          begin
            READDATA <= {16'h0000, mdio_cap_q};
            WAITREQUEST <= 1'b0;
            st_q <= msi_pkg::MSI_DONE;
          end
        end
        msi_pkg::MSI_DONE:
        begin
          WAITREQUEST <= 1'b1;
          st_q <= msi_pkg::MSI_IDLE;
        end
        default:
        begin
          WAITREQUEST <= 1'b1;
          st_q <= msi_pkg::MSI_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    case (ADDRESS)
      `MSI_OFS_CMD: rd_mux = cmd_q;
      `MSI_OFS_MAC0: rd_mux = mac0_q;
      `MSI_OFS_MAC1: rd_mux = {16'h0000, mac1_q};
      `MSI_OFS_FRM_LEN: rd_mux = {16'h0000, frm_len_q};
      `MSI_OFS_PAUSE: rd_mux = {16'h0000, pause_q};
      `MSI_OFS_RX_SEC_EMPTY: rd_mux = {16'h0000, rx_se_q};
      `MSI_OFS_RX_SEC_FULL: rd_mux = {16'h0000, rx_sf_q};
      `MSI_OFS_TX_SEC_EMPTY: rd_mux = {16'h0000, tx_se_q};
      `MSI_OFS_TX_SEC_FULL: rd_mux = {16'h0000, tx_sf_q};
      `MSI_OFS_RX_AE: rd_mux = {16'h0000, rx_ae_q};
      `MSI_OFS_RX_AF: rd_mux = {16'h0000, rx_af_q};
      `MSI_OFS_TX_AE: rd_mux = {16'h0000, tx_ae_q};
      `MSI_OFS_TX_AF: rd_mux = {16'h0000, tx_af_q};
      `MSI_OFS_PHY_ADDR0: rd_mux = {27'h0000000, phy_addr_q};
      `MSI_OFS_PCS_CTRL: rd_mux = {16'h0000, pcs_ctrl_q};
      `MSI_OFS_IPG: rd_mux = {16'h0000, ipg_q};
      `MSI_OFS_TIMER_LO: rd_mux = {16'h0000, tmr_lo_q};
      `MSI_OFS_TIMER_HI: rd_mux = {16'h0000, tmr_hi_q};
      `MSI_OFS_IF_MODE: rd_mux = {16'h0000, if_mode_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Plain configuration registers
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      mac0_q <= 32'h00000000;
      {mac1_q, frm_len_q, ipg_q, pause_q, tmr_lo_q, tmr_hi_q} <= '0;
      {tx_se_q, tx_sf_q, rx_se_q, rx_sf_q, tx_ae_q, tx_af_q, rx_ae_q, rx_af_q} <= '0;
      if_mode_q <= 16'h0000; // RL14
      phy_addr_q <= 5'h00;
    end
    else if (acc_wr)
    begin
      case (ADDRESS)
        `MSI_OFS_MAC0: mac0_q <= WRITEDATA; // RL9
        `MSI_OFS_MAC1: mac1_q <= WRITEDATA[15:0]; // RL9
        `MSI_OFS_FRM_LEN: frm_len_q <= WRITEDATA[15:0];
        `MSI_OFS_PAUSE: pause_q <= WRITEDATA[15:0];
        `MSI_OFS_RX_SEC_EMPTY: rx_se_q <= WRITEDATA[15:0];
        `MSI_OFS_RX_SEC_FULL: rx_sf_q <= WRITEDATA[15:0];
        `MSI_OFS_TX_SEC_EMPTY: tx_se_q <= WRITEDATA[15:0];
        `MSI_OFS_TX_SEC_FULL: tx_sf_q <= WRITEDATA[15:0];
        `MSI_OFS_RX_AE: rx_ae_q <= WRITEDATA[15:0];
        `MSI_OFS_RX_AF: rx_af_q <= WRITEDATA[15:0];
        `MSI_OFS_TX_AE: tx_ae_q <= WRITEDATA[15:0];
        `MSI_OFS_TX_AF: tx_af_q <= WRITEDATA[15:0];
        `MSI_OFS_PHY_ADDR0: phy_addr_q <= WRITEDATA[4:0]; // RL19
        `MSI_OFS_IPG: ipg_q <= WRITEDATA[15:0];
        `MSI_OFS_TIMER_LO: tmr_lo_q <= WRITEDATA[15:0];
        `MSI_OFS_TIMER_HI: tmr_hi_q <= WRITEDATA[15:0];
        `MSI_OFS_IF_MODE: if_mode_q <= WRITEDATA[15:0] & `MSI_IFM_WMASK; // RL20
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Command word with self-clearing reset
  // ----------------------------------------
  logic [15:0] mac_rst_cnt_q;
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      cmd_q <= `MSI_CMD_RST;
      mac_rst_cnt_q <= 16'h0000;
    end
    else if (acc_wr && ADDRESS == `MSI_OFS_CMD)
    begin
      // Reserved bits stay zero; reset bit is set-only
      cmd_q <= (WRITEDATA & `MSI_CMD_WMASK) | (cmd_q & (32'h1 << `MSI_CMD_SOFT_RST)); // RL5 RL6
      if (WRITEDATA[`MSI_CMD_SOFT_RST])
      begin
        mac_rst_cnt_q <= 16'(MAC_RST_CYC); // RL2
      end
    end
    else if (cmd_q[`MSI_CMD_SOFT_RST])
    begin
      if (mac_rst_cnt_q <= 16'h0001)
      begin
        cmd_q[`MSI_CMD_SOFT_RST] <= 1'b0; // RL2
        mac_rst_cnt_q <= 16'h0000;
      end
      else
      begin
        mac_rst_cnt_q <= mac_rst_cnt_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Sublayer control with self-clearing reset
  // ----------------------------------------
  logic [15:0] pcs_rst_cnt_q;
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pcs_ctrl_q <= `MSI_PCS_CTRL_RST;
      pcs_rst_cnt_q <= 16'h0000;
    end
    else if (acc_wr && ADDRESS == `MSI_OFS_PCS_CTRL)
    begin
      if (if_mode_q[`MSI_IFM_SGMII])
      begin
        pcs_ctrl_q <= WRITEDATA[15:0] | (pcs_ctrl_q & (16'h1 << `MSI_PCS_RST_BIT)); // RL15
      end
      else
      begin
        pcs_ctrl_q <= ((WRITEDATA[15:0] & ~`MSI_PCS_RO_MASK) | (pcs_ctrl_q & `MSI_PCS_RO_MASK))
                      | (pcs_ctrl_q & (16'h1 << `MSI_PCS_RST_BIT)); // RL16
      end
      if (WRITEDATA[`MSI_PCS_RST_BIT])
      begin
        pcs_rst_cnt_q <= 16'(PCS_RST_CYC); // RL17
      end
    end
    else if (pcs_ctrl_q[`MSI_PCS_RST_BIT])
    begin
      if (pcs_rst_cnt_q <= 16'h0001)
      begin
        pcs_ctrl_q[`MSI_PCS_RST_BIT] <= 1'b0; // RL17
        pcs_rst_cnt_q <= 16'h0000;
      end
      else
      begin
        pcs_rst_cnt_q <= pcs_rst_cnt_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Outputs to datapath
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      CFG <= '0;
      MAC_RESET <= 1'b0;
      PCS_RESET <= 1'b0;
      TX_STORE_FWD <= 1'b1;
      RX_STORE_FWD <= 1'b1;
    end
    else
    begin
      CFG <= '{command: cmd_q, station: {mac1_q, mac0_q}, frm_len: frm_len_q, ipg: ipg_q, pause: pause_q,
               tx_sec_empty: tx_se_q, tx_sec_full: tx_sf_q, rx_sec_empty: rx_se_q, rx_sec_full: rx_sf_q,
               tx_ae: tx_ae_q, tx_af: tx_af_q, rx_ae: rx_ae_q, rx_af: rx_af_q,
               autoneg_timer: {tmr_hi_q, tmr_lo_q}, if_mode: if_mode_q, pcs_ctrl: pcs_ctrl_q};
      MAC_RESET <= cmd_q[`MSI_CMD_SOFT_RST]; // RL2
      PCS_RESET <= pcs_ctrl_q[`MSI_PCS_RST_BIT]; // RL17
      TX_STORE_FWD <= (tx_sf_q == 16'h0000); // RL8
      RX_STORE_FWD <= (rx_sf_q == 16'h0000); // RL8
    end
  end

  // ----------------------------------------
  // MDIO engine
  // ----------------------------------------
  logic mdio_s1_q, mdio_s2_q;
  logic [63:0] frame_q;
  logic [5:0] bit_q;
  logic [7:0] div_q;
  logic rd_op_q;
  logic mdio_go;
  assign mdio_go = (st_q == msi_pkg::MSI_IDLE) && req && is_mdio;
  assign mdio_done = (st_q == msi_pkg::MSI_MDIO) && MDC && (div_q == 8'(MDC_DIV - 1)) && (bit_q == `MSI_MDIO_LAST);

  always_ff @(posedge CLK)
  begin
    mdio_s1_q <= MDIO_IN;
    mdio_s2_q <= mdio_s1_q;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      MDC <= 1'b0;
      MDIO_OUT <= 1'b1;
      MDIO_OE_N <= 1'b1;
      frame_q <= '0;
      bit_q <= 6'h00;
      div_q <= 8'h00;
      rd_op_q <= 1'b0;
      mdio_cap_q <= 16'h0000;
    end
    else if (mdio_go)
    begin
      rd_op_q <= !WRITE;
      // Preamble, start, opcode, PHY, register, turnaround, data
      frame_q <= {32'hFFFFFFFF, 2'b01, (WRITE ? 2'b01 : 2'b10), phy_addr_q, ADDRESS[4:0],
                  (WRITE ? {2'b10, WRITEDATA[15:0]} : 18'h3FFFF)}; // RL19
      MDIO_OUT <= 1'b1;
      MDIO_OE_N <= 1'b0;
      bit_q <= 6'h00;
      div_q <= 8'h00;
      MDC <= 1'b0;
    end
    else if (st_q == msi_pkg::MSI_MDIO)
    begin
      if (div_q == 8'(MDC_DIV - 1))
      begin
        div_q <= 8'h00;
        MDC <= !MDC;
        if (!MDC && rd_op_q && bit_q >= `MSI_MDIO_RX_DAT)
        begin
          mdio_cap_q <= {mdio_cap_q[14:0], mdio_s2_q};
        end
        if (MDC && bit_q != `MSI_MDIO_LAST)
        begin
          bit_q <= bit_q + 6'h01;
          MDIO_OUT <= frame_q[62];
          frame_q <= {frame_q[62:0], 1'b1};
          MDIO_OE_N <= rd_op_q && (bit_q + 6'h01 >= `MSI_MDIO_RX_REL);
        end
        else if (MDC)
        begin
          MDIO_OE_N <= 1'b1;
          MDIO_OUT <= 1'b1;
        end
      end
      else
      begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_mac_rst_clear;
    @(posedge CLK) disable iff (RESET) $rose(cmd_q[`MSI_CMD_SOFT_RST]) |-> ##[1:20] !cmd_q[`MSI_CMD_SOFT_RST];
  endproperty
  a_mac_rst_clear: assert property (p_mac_rst_clear) else $error("MAC reset bit did not clear"); // RL2
  property p_mac_rst_out;
    @(posedge CLK) disable iff (RESET)
      (acc_wr && ADDRESS == `MSI_OFS_CMD && WRITEDATA[`MSI_CMD_SOFT_RST]) |-> ##2 MAC_RESET;
  endproperty
  a_mac_rst_out: assert property (p_mac_rst_out) else $error("MAC reset output missing"); // RL2
  property p_pcs_rst_clear;
    @(posedge CLK) disable iff (RESET) $rose(pcs_ctrl_q[`MSI_PCS_RST_BIT]) |-> ##[1:20] !pcs_ctrl_q[`MSI_PCS_RST_BIT];
  endproperty
  a_pcs_rst_clear: assert property (p_pcs_rst_clear) else $error("Sublayer reset bit did not clear"); // RL17
  property p_pcs_ro;
    @(posedge CLK) disable iff (RESET)
      (acc_wr && ADDRESS == `MSI_OFS_PCS_CTRL && !if_mode_q[`MSI_IFM_SGMII])
      |=> ((pcs_ctrl_q & `MSI_PCS_RO_MASK) == ($past(pcs_ctrl_q) & `MSI_PCS_RO_MASK));
  endproperty
  a_pcs_ro: assert property (p_pcs_ro) else $error("Read-only control bits changed"); // RL16
  property p_store_fwd;
    @(posedge CLK) disable iff (RESET)
      (acc_wr && ADDRESS == `MSI_OFS_TX_SEC_FULL) |-> ##2 (TX_STORE_FWD == ($past(WRITEDATA[15:0], 2) == 16'h0000));
  endproperty
  a_store_fwd: assert property (p_store_fwd) else $error("Store-and-forward select wrong"); // RL8
  property p_station;
    @(posedge CLK) disable iff (RESET)
      (acc_wr && ADDRESS == `MSI_OFS_MAC0) |-> ##2 (CFG.station[7:0] == $past(WRITEDATA[7:0], 2));
  endproperty
  a_station: assert property (p_station) else $error("First octet not in low byte"); // RL9
  property p_mode;
    @(posedge CLK) disable iff (RESET)
      (acc_wr && ADDRESS == `MSI_OFS_IF_MODE) |-> ##2 (CFG.if_mode[1:0] == $past(WRITEDATA[1:0], 2));
  endproperty
  a_mode: assert property (p_mode) else $error("Interface mode not applied"); // RL20
  property p_reg_ack;
    @(posedge CLK) disable iff (RESET) (acc_wr || acc_rd) |=> !WAITREQUEST ##1 WAITREQUEST;
  endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("Register access not answered in one cycle"); // RL21
  property p_mdio_busy;
    @(posedge CLK) disable iff (RESET) mdio_go |=> WAITREQUEST [*8];
  endproperty
  a_mdio_busy: assert property (p_mdio_busy) else $error("Busy dropped during MDIO access"); // RL19
  property p_resv_zero;
    @(posedge CLK) disable iff (RESET) (acc_rd && ADDRESS == `MSI_OFS_CMD) |=> (READDATA[30:27] == 4'h0);
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("Reserved command bits not zero"); // RL6
  property p_cov_mdio;
    @(posedge CLK) disable iff (RESET) mdio_done && rd_op_q;
  endproperty
  c_cov_mdio: cover property (p_cov_mdio);
  property p_cov_mac_rst;
    @(posedge CLK) disable iff (RESET) $fell(cmd_q[`MSI_CMD_SOFT_RST]);
  endproperty
  c_cov_mac_rst: cover property (p_cov_mac_rst);
  property p_cov_pcs_rst;
    @(posedge CLK) disable iff (RESET) $fell(pcs_ctrl_q[`MSI_PCS_RST_BIT]);
  endproperty
  c_cov_pcs_rst: cover property (p_cov_pcs_rst);
endmodule : msi_init_regs

// ==== msi_defs.svh ====
`ifndef MSI_DEFS_SVH
`define MSI_DEFS_SVH
// ----------------------------------------
// Word offsets
// ----------------------------------------
`define MSI_OFS_CMD 8'h02
`define MSI_OFS_MAC0 8'h03
`define MSI_OFS_MAC1 8'h04
`define MSI_OFS_FRM_LEN 8'h05
`define MSI_OFS_PAUSE 8'h06
`define MSI_OFS_RX_SEC_EMPTY 8'h07
`define MSI_OFS_RX_SEC_FULL 8'h08
`define MSI_OFS_TX_SEC_EMPTY 8'h09
`define MSI_OFS_TX_SEC_FULL 8'h0A
`define MSI_OFS_RX_AE 8'h0B
`define MSI_OFS_RX_AF 8'h0C
`define MSI_OFS_TX_AE 8'h0D
`define MSI_OFS_TX_AF 8'h0E
`define MSI_OFS_PHY_ADDR0 8'h0F
`define MSI_OFS_PCS_CTRL 8'h10
`define MSI_OFS_IPG 8'h11
`define MSI_OFS_TIMER_LO 8'h12
`define MSI_OFS_TIMER_HI 8'h13
`define MSI_OFS_IF_MODE 8'h14
`define MSI_OFS_MDIO_LO 8'h80
`define MSI_OFS_MDIO_HI 8'h9F
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define MSI_CMD_SOFT_RST 13
`define MSI_CMD_WMASK 32'h87FFFFFF
`define MSI_CMD_RST 32'h00000000
`define MSI_PCS_RST_BIT 15
`define MSI_PCS_RO_MASK 16'h2140
`define MSI_PCS_CTRL_RST 16'h1140
`define MSI_IFM_SGMII 0
`define MSI_IFM_WMASK 16'h003F
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define MSI_MAC_RST_CYC 16
`define MSI_PCS_RST_CYC 16
`define MSI_MDC_DIV 50
`define MSI_MDIO_LAST 6'h3F
`define MSI_MDIO_RX_REL 6'h2E
`define MSI_MDIO_RX_DAT 6'h30
`endif

// ==== msi_pkg.sv ====
package msi_pkg;
  typedef enum logic [1:0] {MSI_IDLE, MSI_MDIO, MSI_DONE} msi_state_t;

  typedef struct packed {
    logic [31:0] command;
    logic [47:0] station;
    logic [15:0] frm_len;
    logic [15:0] ipg;
    logic [15:0] pause;
    logic [15:0] tx_sec_empty;
    logic [15:0] tx_sec_full;
    logic [15:0] rx_sec_empty;
    logic [15:0] rx_sec_full;
    logic [15:0] tx_ae;
    logic [15:0] tx_af;
    logic [15:0] rx_ae;
    logic [15:0] rx_af;
    logic [31:0] autoneg_timer;
    logic [15:0] if_mode;
    logic [15:0] pcs_ctrl;
  } msi_cfg_t;
endpackage : msi_pkg

// ==== msi_phy_model.sv ====
module msi_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h0A
) (
  // Management wire
  input wire logic mdc,
  input wire logic mdio,
  // Drive back onto the wire
  output logic drv_oe,
  output logic drv_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [32];
  logic [33:0] sr;
  logic [4:0] ra;
  logic rd;
  int n;
  initial
  begin
    drv_oe = 1'b0;
    drv_val = 1'b1;
    sr = '0;
    ra = '0;
    rd = 1'b0;
    n = -1;
    foreach (regs[i]) regs[i] = 16'h0000;
  end
  // Frame decode on rising MDC
  always @(posedge mdc)
  begin
    sr = {sr[32:0], mdio};
    if (n < 0)
    begin
      if (sr == {32'hFFFFFFFF, 2'b01}) n = 2;
    end
    else
    begin
      n++;
      if (n == 14)
      begin
        rd = (sr[11:10] == 2'b10) && (sr[9:5] == PHY_ADDR);
        ra = sr[4:0];
      end
      if (n == 32)
      begin
        if (sr[29:28] == 2'b01 && sr[27:23] == PHY_ADDR) regs[sr[22:18]] = sr[15:0];
        n = -1;
        rd = 1'b0;
        sr = '0;
      end
    end
  end
  // Turnaround zero then data, changed after falling MDC
  always @(negedge mdc)
  begin
    drv_oe = rd && (n >= 15) && (n <= 31);
    drv_val = (n >= 16 && n <= 31) ? regs[ra][31 - n] : 1'b0;
  end
endmodule : msi_phy_model

// ==== mac_pcs_init_sequencer_bench.sv ====
`include "msi_defs.svh"
module mac_pcs_init_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  logic clk, rst, rd, wr, mdc, mdio_out, mdio_oe_n, mdio_w, wait_req, mac_rst, pcs_rst, tx_sf, rx_sf, phy_oe, phy_val;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  msi_pkg::msi_cfg_t cfg;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  assign mdio_w = (mdio_oe_n === 1'b0) ? mdio_out : ((phy_oe === 1'b1) ? phy_val : 1'b1);
  msi_init_regs #(.MDC_DIV(DIV), .MAC_RST_CYC(16), .PCS_RST_CYC(16)) dut (.CLK(clk), .RESET(rst), .READ(rd),
    .WRITE(wr), .ADDRESS(addr), .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(wait_req), .MDC(mdc),
    .MDIO_OUT(mdio_out), .MDIO_OE_N(mdio_oe_n), .MDIO_IN(mdio_w), .CFG(cfg), .MAC_RESET(mac_rst),
    .PCS_RESET(pcs_rst), .TX_STORE_FWD(tx_sf), .RX_STORE_FWD(rx_sf));
  msi_phy_model #(.PHY_ADDR(5'h0A)) phy (.mdc(mdc), .mdio(mdio_w), .drv_oe(phy_oe), .drv_val(phy_val));
  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    while (wait_req !== 1'b0) @(negedge clk);
    q = rdata;
    // Hold the request through the edge that samples the answer
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask : acc
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wrc
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    acc(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask : rdc
  // Reads until a self-clearing bit drops; returns the number of extra reads
  task automatic poll(input logic [7:0] a, input int b, output int k);
    k = 0;
    acc(1'b0, a, 32'h0);
    while (q[b] === 1'b1 && k < 30)
    begin
      k++;
      acc(1'b0, a, 32'h0);
    end
  endtask : poll
  function automatic logic [15:0] pcs_exp(input logic [15:0] old, input logic [15:0] d, input logic sg);
    return sg ? d : ((d & ~`MSI_PCS_RO_MASK) | (old & `MSI_PCS_RO_MASK));
  endfunction : pcs_exp
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [4:0] r;
    logic [15:0] v, old;
    logic [31:0] d;
    int k;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    void'($urandom(80016));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rdc(`MSI_OFS_CMD, 32'h0, "cmd_reset");
    rdc(`MSI_OFS_PCS_CTRL, 32'h1140, "pcs_ctrl_reset");
    chk("store_fwd_reset", 32'h3, {30'h0, tx_sf, rx_sf});
    $display("test reset done");
    wrc(`MSI_OFS_PHY_ADDR0, 32'h0000000A);
    for (int i = 0; i < 2; i++)
    begin
      r = i ? 5'h1F : 5'($urandom);
      v = 16'($urandom);
      wrc({3'b100, r}, {16'h0, v});
      rdc({3'b100, r}, {16'h0, v}, "mdio_readback");
    end
    wrc(`MSI_OFS_PHY_ADDR0, 32'h0000000B);
    rdc({3'b100, r}, 32'h0000FFFF, "mdio_other_phy");
    $display("test mdio done");
    old = 16'h1140;
    for (int m = 0; m < 2; m++)
    begin
      wrc(`MSI_OFS_TIMER_LO, m ? 32'hFFFF12D0 : 32'h00000D40);
      wrc(`MSI_OFS_TIMER_HI, m ? 32'h00000013 : 32'h00000003);
      wrc(`MSI_OFS_IF_MODE, m ? 32'h0 : 32'h3);
      rdc(`MSI_OFS_TIMER_LO, m ? 32'h12D0 : 32'h0D40, "timer_low");
      chk("autoneg_timer", m ? 32'h001312D0 : 32'h00030D40, cfg.autoneg_timer);
      rdc(`MSI_OFS_IF_MODE, m ? 32'h0 : 32'h3, "if_mode");
      for (k = 0; k < 3; k++)
      begin
        d = (k == 2) ? 32'h1140 : {17'h0, 15'($urandom)};
        wrc(`MSI_OFS_PCS_CTRL, d);
        old = pcs_exp(old, d[15:0], m == 0);
        rdc(`MSI_OFS_PCS_CTRL, {16'h0, old}, "pcs_ctrl");
      end
      wrc(`MSI_OFS_PCS_CTRL, 32'h00009140);
      chk("pcs_reset_out", 32'h1, {31'h0, pcs_rst});
      poll(`MSI_OFS_PCS_CTRL, 15, k);
      chk("pcs_reset_length", 32'h1, {31'h0, k >= 3 && k <= 9});
      chk("pcs_after_reset", {16'h0, old}, q);
    end
    $display("test sublayer done");
    wrc(`MSI_OFS_CMD, 32'h00800220);
    rdc(`MSI_OFS_CMD, 32'h00800220, "cmd_disabled");
    wrc(`MSI_OFS_CMD, 32'h00802220);
    chk("mac_reset_out", 32'h1, {31'h0, mac_rst});
    poll(`MSI_OFS_CMD, 13, k);
    chk("mac_reset_length", 32'h1, {31'h0, k >= 3 && k <= 9});
    chk("mac_reset_end", 32'h0, {31'h0, mac_rst});
    chk("cmd_after_reset", 32'h00800220, q);
    wrc(`MSI_OFS_CMD, 32'h00002000);
    wrc(`MSI_OFS_CMD, 32'h0);
    rdc(`MSI_OFS_CMD, 32'h00002000, "zero_keeps_reset");
    poll(`MSI_OFS_CMD, 13, k);
    for (k = 0; k < 5; k++)
    begin
      d = (k == 0) ? 32'hFFFFDFFF : ($urandom & 32'hFFFFDFFF);
      wrc(`MSI_OFS_CMD, d);
      rdc(`MSI_OFS_CMD, d & `MSI_CMD_WMASK, "cmd_word");
    end
    wrc(`MSI_OFS_CMD, 32'h00800223);
    rdc(`MSI_OFS_CMD, 32'h00800223, "cmd_enable");
    chk("cfg_command", 32'h00800223, cfg.command);
    $display("test command done");
    for (int a = 5; a <= 17; a++)
    begin
      d = $urandom;
      if (a != 15 && a != 16)
      begin
        wrc(8'(a), d);
        rdc(8'(a), {16'h0, d[15:0]}, "threshold_reg");
      end
    end
    for (k = 0; k < 2; k++)
    begin
      wrc(`MSI_OFS_TX_SEC_FULL, k ? 32'd16 : 32'd0);
      wrc(`MSI_OFS_RX_SEC_FULL, k ? 32'd0 : 32'd16);
      chk("store_fwd", k ? 32'h1 : 32'h2, {30'h0, tx_sf, rx_sf});
    end
    wrc(`MSI_OFS_FRM_LEN, 32'd1518);
    chk("frame_length", 32'd1518, {16'h0, cfg.frm_len});
    wrc(`MSI_OFS_MAC0, 32'h17231C00);
    wrc(`MSI_OFS_MAC1, 32'hFFFFCB4A);
    rdc(`MSI_OFS_MAC0, 32'h17231C00, "station_low");
    rdc(`MSI_OFS_MAC1, 32'h0000CB4A, "station_high");
    chk("cfg_station_low", 32'h17231C00, cfg.station[31:0]);
    wrc(8'h40, $urandom);
    rdc(8'h40, 32'h0, "unmapped");
    $display("test mac setup done");
    tally_and_finish();
  end
endmodule : mac_pcs_init_sequencer_bench
